// ==== tb/branch_call_clear_exec_tb.sv ====
// self-checking bench for the branch, call and clear execute block
`timescale 1ns/100ps
module branch_call_clear_exec_tb;
    import branch_call_clear_pkg::*;

    logic                CLK_SYS, ARST_N, CE, DM_RD, DM_WR, Z_SET, STACK_PUSH;
    logic                PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic [PC_W-1:0]     PROG_ADDR, RETURN_TOP, pc_exp, ret_exp, npc, p0;
    logic [15:0]         INSTR_DATA, w1, w2;
    logic [DM_W-1:0]     DM_ADDR, ea, addr;
    logic [7:0]          DM_RDATA, DM_WDATA, W_IN, WORKING_SHADOW, nw, f, n, ewd, wd;
    logic [STAT_W-1:0]   STATUS_IN, FLAGS_SHADOW, nst;
    logic [BANK_W-1:0]   BANK_SELECT_IN, BANK_SELECT_SHADOW, nbk;
    logic [APB_AW-1:0]   PADDR;
    logic [31:0]         PWDATA, PRDATA, sh_exp, rd, r;
    logic [19:0]         k;
    logic [11:0]         sig, esig;
    logic [2:0]          b;
    logic                a, s, taken, er;
    int                  err_count, n_compared, cycles, seed, kind;
    int                  ck [9] = '{2, 3, 2, 3, 4, 4, 1, 1, 0};

    branch_call_clear_exec branch_call_clear_exec_i (
        .CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .CE(CE), .PROG_ADDR(PROG_ADDR), .INSTR_DATA(INSTR_DATA),
        .DM_ADDR(DM_ADDR), .DM_RD(DM_RD), .DM_RDATA(DM_RDATA), .DM_WR(DM_WR), .DM_WDATA(DM_WDATA),
        .W_IN(W_IN), .STATUS_IN(STATUS_IN), .BANK_SELECT_IN(BANK_SELECT_IN), .Z_SET(Z_SET),
        .STACK_PUSH(STACK_PUSH), .RETURN_TOP(RETURN_TOP), .WORKING_SHADOW(WORKING_SHADOW),
        .FLAGS_SHADOW(FLAGS_SHADOW), .BANK_SELECT_SHADOW(BANK_SELECT_SHADOW), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR));

    fetch_store_model fetch_store_model_i (
        .clk(CLK_SYS), .prog_addr(PROG_ADDR), .instr_data(INSTR_DATA), .dm_addr(DM_ADDR),
        .dm_rd(DM_RD), .dm_rdata(DM_RDATA), .dm_wr(DM_WR), .dm_wdata(DM_WDATA));

    // ------------------------------------------------------------------
    // clock, timeout, reporting
    // ------------------------------------------------------------------
    initial begin
        CLK_SYS = 1'b0;
        forever #2 CLK_SYS = ~CLK_SYS;
    end

    always @(posedge CLK_SYS) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("compared %0d, errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        n_compared++;
        if (seen !== expected) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask

    // ------------------------------------------------------------------
    // bus and instruction drivers
    // ------------------------------------------------------------------
    task automatic apb(input logic wr, input logic [APB_AW-1:0] ad, input logic [31:0] wdat);
        @(posedge CLK_SYS);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= ad;
        PWDATA <= wdat;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        do @(posedge CLK_SYS); while (PREADY !== 1'b1);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    // entered in a Q1 period; samples Q2, Q3, Q4 and ends in the next Q1
    task automatic step(input logic [15:0] i1, input logic [15:0] i2);
        sig = 12'h000;
        fetch_store_model_i.put_word(pc_exp, i1);
        fetch_store_model_i.put_word(pc_exp + PC_STEP, i2);
        for (int p = 0; p < 4; p++) begin
            @(posedge CLK_SYS);
            // next instruction's core inputs change only after this one's Q4
            if (p == 3) begin
                W_IN <= nw;
                STATUS_IN <= nst;
                BANK_SELECT_IN <= nbk;
            end
            @(negedge CLK_SYS);
            if (p < 3) begin
                sig[9+p] = DM_RD;
                sig[6+p] = DM_WR;
                sig[3+p] = STACK_PUSH;
                sig[p] = Z_SET;
            end
            if (p == 0) addr = DM_ADDR;
            if (p == 2) wd = DM_WDATA;
        end
    endtask

    task automatic nop_run(input int cnt);
        repeat (cnt) begin
            step(OP_NOP, OP_NOP);
            pc_exp = pc_exp + PC_STEP;
            check(PROG_ADDR, pc_exp);
        end
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        seed = 32'hf498;
        {ARST_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
        CE = 1'b1;
        {W_IN, STATUS_IN, BANK_SELECT_IN} = {8'h5A, 5'h1F, 4'h3};
        {nw, nst, nbk} = {8'h5A, 5'h1F, 4'h3};
        {pc_exp, ret_exp, sh_exp} = '0;
        repeat (5) @(posedge CLK_SYS);
        @(negedge CLK_SYS);
        check({RETURN_TOP, STACK_PUSH, DM_WR, DM_RD, Z_SET}, 32'h0);
        check({PROG_ADDR, WORKING_SHADOW}, 32'h0);
        @(posedge CLK_SYS);
        ARST_N <= 1'b1;
        @(negedge CLK_SYS);
        for (int i = 0; i < 150; i++) begin
            r = $random(seed);
            kind = (i < 9) ? ck[i] : int'(r[31:16] % 16'h0006);
            {f, b, a, s, n} = {r[7:0], r[10:8], r[11], r[8], r[7:0]};
            k = 20'($random(seed));
            case (i)
                0: n = 8'h80;
                1: n = 8'h7F;
                4: {s, k} = {1'b1, 20'hFFFFF};
                5: {s, k} = {1'b0, 20'h00000};
                6: {a, f} = {1'b0, 8'h7F};
                7: {a, f} = {1'b0, 8'h80};
                8: {a, b} = {1'b1, 3'h7};
                default: ;
            endcase
            nst = (i == 0) ? 5'h1F : (i == 1) ? 5'h04 : (i == 2) ? 5'h08 : 5'($random(seed));
            nw = 8'($random(seed));
            nbk = 4'($random(seed));
            w2 = OP_NOP;
            case (kind)
                0: w1 = {OP_BIT_TOGGLE, b, a, f};
                1: w1 = {OP_CLEAR_REG, a, f};
                2: w1 = {OP_BRANCH_OVF, n};
                3: w1 = {OP_BRANCH_ZERO, n};
                4: {w1, w2} = {OP_CALL_FIRST, s, k[7:0], OP_CALL_SECOND, k[19:8]};
                default: w1 = OP_NOP;
            endcase
            ea = {a ? BANK_SELECT_IN : (f < ACCESS_SPLIT ? ACCESS_LO_BANK : ACCESS_HI_BANK), f};
            ewd = (kind == 0) ? fetch_store_model_i.dmem[ea] ^ (8'h01 << b) : 8'h00;
            taken = (kind == 2 && STATUS_IN[FLAG_OV]) || (kind == 3 && STATUS_IN[FLAG_Z]) || kind == 4;
            npc = taken ? pc_exp + PC_STEP + {{12{n[7]}}, n, 1'b0} : pc_exp + PC_STEP;
            esig = (kind == 0) ? 12'h700 : (kind == 1) ? 12'h704 : (kind == 4) ? 12'h010 : 12'h000;
            if (kind == 4) begin
                npc = {k, 1'b0};
                ret_exp = pc_exp + PC_STEP + PC_STEP;
                if (s) sh_exp = {12'h000, BANK_SELECT_IN, 3'h0, STATUS_IN, W_IN};
            end
            step(w1, w2);
            check(sig, esig);
            if (kind < 2) begin
                check(addr, ea);
                check(wd, ewd);
            end
            pc_exp = npc;
            check(PROG_ADDR, pc_exp);
            check(RETURN_TOP, ret_exp);
            check({BANK_SELECT_SHADOW, 3'h0, FLAGS_SHADOW, WORKING_SHADOW}, sh_exp);
            if (taken) begin
                // a clear placed at the target must not run during the idle cycle
                step({OP_CLEAR_REG, 1'b0, 8'h10}, OP_NOP);
                check(sig, 12'h000);
                check(PROG_ADDR, pc_exp);
            end
        end
        // enable low in mid-instruction: phase and pc must hold until it returns
        fetch_store_model_i.put_word(pc_exp, OP_NOP);
        @(posedge CLK_SYS);
        CE <= 1'b0;
        repeat (5) @(posedge CLK_SYS);
        @(negedge CLK_SYS);
        check(PROG_ADDR, pc_exp + PC_STEP);
        @(posedge CLK_SYS);
        CE <= 1'b1;
        repeat (3) @(posedge CLK_SYS);
        @(negedge CLK_SYS);
        pc_exp = pc_exp + PC_STEP;
        check(PROG_ADDR, pc_exp);
        p0 = pc_exp;
        fork
            nop_run(5);
            begin
                apb(1'b0, REG_PC, 32'h0);
                check(rd, p0 + PC_STEP);
                check(er, 1'b0);
                apb(1'b0, REG_CTRL, 32'h0);
                check(rd[CTRL_RUN], CTRL_RESET_RUN);
                apb(1'b1, REG_RETTOP, 32'hFFFFFFFF);
                apb(1'b0, REG_RETTOP, 32'h0);
                check(rd, ret_exp);
                apb(1'b0, REG_SHADOW, 32'h0);
                check(rd, sh_exp);
                apb(1'b0, 12'h010, 32'h0);
                check(rd, 32'h0000_0000);
                check(er, 1'b1);
            end
        join
        fork
            nop_run(1);
            apb(1'b1, REG_CTRL, 32'h0);
        join
        repeat (12) @(negedge CLK_SYS);
        check(PROG_ADDR, pc_exp);
        stop_test();
    end
endmodule

// ==== tb/fetch_store_model.sv ====
// program and data memory model facing the execute block
`timescale 1ns/100ps
module fetch_store_model (
    // clock
    input  wire logic                                   clk,
    // program memory
    input  wire logic [branch_call_clear_pkg::PC_W-1:0] prog_addr,
    output logic      [15:0]                            instr_data,
    // data memory
    input  wire logic [branch_call_clear_pkg::DM_W-1:0] dm_addr,
    input  wire logic                                   dm_rd,
    output logic      [7:0]                             dm_rdata,
    input  wire logic                                   dm_wr,
    input  wire logic [7:0]                             dm_wdata
);
    import branch_call_clear_pkg::*;

    // sparse, so a call may land anywhere in the two megabyte space
    logic [15:0] prog [int];
    logic [7:0]  dmem [0:4095];

    function automatic logic [15:0] word_at(input logic [PC_W-1:0] a);
        return prog.exists(int'(a[PC_W-1:1])) ? prog[int'(a[PC_W-1:1])] : OP_NOP;
    endfunction

    task automatic put_word(input logic [PC_W-1:0] a, input logic [15:0] d);
        prog[int'(a[PC_W-1:1])] = d;
        instr_data = word_at(prog_addr);
    endtask

    initial begin
        dm_rdata = 8'h00;
        for (int i = 0; i < 4096; i++) begin
            dmem[i] = 8'(i * 37 + 11);
        end
    end

    always @(prog_addr) begin
        instr_data = word_at(prog_addr);
    end

    // outside a read each change of dm_rd or dm_addr inverts the bus, so two changes bring back a stale copy
    always @(dm_rd or dm_addr) begin
        if (dm_rd) begin
            dm_rdata = dmem[dm_addr];
        end else begin
            dm_rdata = ~dm_rdata;
        end
    end

    always @(posedge clk) begin
        if (dm_wr) begin
            dmem[dm_addr] <= dm_wdata;
        end
    end
endmodule

// ==== verilog/branch_call_clear_exec.sv ====
// execute logic for toggle, conditional branches, call and clear
// Overview of operation
// - toggle bit b of f, flags kept
// - overflow branch: fixed upper byte, offset low
// - overflow branch taken only when flag set
// - zero branch: fixed upper byte, offset low
// - zero branch taken only when flag set
// - offset signed, doubled, added to pc
// - target is incremented pc plus doubled offset
// - taken: two cycles, idle second; else one
// - offset in Q2, Q3 process, Q4 pc write
// - call is two words, fast flag first
// - call reaches full two megabyte space
// - call pushes call address plus four
// - fast call copies working, flags, bank
// - plain call leaves shadows unchanged
// - call loads literal into pc 20:1
// - call two cycles, idle second, flags kept
// - clear writes zero, sets zero flag
// - access flag chooses access or selected bank
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/100ps
module branch_call_clear_exec (
    // clock, reset, enable
    input  wire logic                                    CLK_SYS,
    input  wire logic                                    ARST_N,
    input  wire logic                                    CE,
    // program memory
    output logic      [branch_call_clear_pkg::PC_W-1:0]  PROG_ADDR,
    input  wire logic [15:0]                             INSTR_DATA,
    // data memory
    output logic      [branch_call_clear_pkg::DM_W-1:0]  DM_ADDR,
    output logic                                         DM_RD,
    input  wire logic [7:0]                              DM_RDATA,
    output logic                                         DM_WR,
    output logic      [7:0]                              DM_WDATA,
    // core registers
    input  wire logic [7:0]                              W_IN,
    input  wire logic [branch_call_clear_pkg::STAT_W-1:0] STATUS_IN,
    input  wire logic [branch_call_clear_pkg::BANK_W-1:0] BANK_SELECT_IN,
    output logic                                         Z_SET,
    // return stack
    output logic                                         STACK_PUSH,
    output logic      [branch_call_clear_pkg::PC_W-1:0]  RETURN_TOP,
    // shadow registers
    output logic      [7:0]                              WORKING_SHADOW,
    output logic      [branch_call_clear_pkg::STAT_W-1:0] FLAGS_SHADOW,
    output logic      [branch_call_clear_pkg::BANK_W-1:0] BANK_SELECT_SHADOW,
    // apb slave
    input  wire logic                                    PSEL,
    input  wire logic                                    PENABLE,
    input  wire logic                                    PWRITE,
    input  wire logic [branch_call_clear_pkg::APB_AW-1:0] PADDR,
    input  wire logic [31:0]                             PWDATA,
    output logic      [31:0]                             PRDATA,
    output logic                                         PREADY,
    output logic                                         PSLVERR
);
    import branch_call_clear_pkg::*;

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    function automatic logic is_toggle(input logic [15:0] op);
        return op[15:12] == OP_BIT_TOGGLE;
    endfunction

    function automatic logic is_bovf(input logic [15:0] op);
        return op[15:8] == OP_BRANCH_OVF;
    endfunction

    function automatic logic is_bzero(input logic [15:0] op);
        return op[15:8] == OP_BRANCH_ZERO;
    endfunction

    function automatic logic is_call(input logic [15:0] op);
        return op[15:9] == OP_CALL_FIRST;
    endfunction

    function automatic logic is_clear(input logic [15:0] op);
        return op[15:9] == OP_CLEAR_REG;
    endfunction

    // access bank covers the low half of bank 0 and the top half of bank 15
    function automatic logic [DM_W-1:0] file_addr(input logic [15:0] op,
                                                  input logic [BANK_W-1:0] bank);
        if (op[ACCESS_FLAG_BIT])
            return {bank, op[7:0]};
        else if (op[7:0] < ACCESS_SPLIT)
            return {ACCESS_LO_BANK, op[7:0]};
        else
            return {ACCESS_HI_BANK, op[7:0]};
    endfunction

    function automatic logic [7:0] bit_mask(input logic [2:0] b);
        return 8'h01 << b;
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        phase_type         q;
        logic              flush;
        logic [15:0]       ir;
        logic [PC_W-1:0]   pc;
        logic [7:0]        data;
        logic              taken;
        logic [7:0]        w_sh;
        logic [STAT_W-1:0] st_sh;
        logic [BANK_W-1:0] bank_sh;
        logic [PC_W-1:0]   return_stack_top;
        logic              push;
        logic [DM_W-1:0]   dm_addr;
        logic              dm_rd;
        logic              dm_wr;
        logic              z_set;
        logic              run;
        logic [31:0]       prdata;
        logic              pslverr;
    } state_type;

    state_type       cur;
    state_type       next_cur;
    logic [PC_W-1:0] branch_target;
    logic            apb_setup;
    logic            apb_write;

    branch_target_calc branch_target_calc_i (
        .pc_now (cur.pc),
        .offset (cur.data),
        .target (branch_target)
    );

    assign apb_setup = PSEL && !PENABLE;
    assign apb_write = PSEL && PENABLE && PWRITE;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_cur       = cur;
        next_cur.push  = 1'b0;
        next_cur.dm_wr = 1'b0;
        next_cur.z_set = 1'b0;

        // a halted core parks at Q1 so it never stops mid-instruction
        unique case (cur.q)
            PH_Q1: begin
                if (cur.run) begin
                    next_cur.q = PH_Q2;
                    if (cur.flush) begin
                        next_cur.ir    = OP_NOP;
                        next_cur.flush = 1'b0;
                    end else begin
                        next_cur.ir      = INSTR_DATA;
                        next_cur.pc      = PC_W'(cur.pc + PC_STEP);
                        next_cur.dm_addr = file_addr(INSTR_DATA, BANK_SELECT_IN);
                        next_cur.dm_rd   = is_toggle(INSTR_DATA) || is_clear(INSTR_DATA);
                    end
                end
            end
            PH_Q2: begin
                next_cur.q    = PH_Q3;
                next_cur.data = cur.ir[7:0];
                if (is_call(cur.ir)) begin
                    next_cur.return_stack_top  = PC_W'(cur.pc + PC_STEP);
                    next_cur.push = 1'b1;
                end
            end
            PH_Q3: begin
                next_cur.q     = PH_Q4;
                next_cur.dm_rd = 1'b0;
                next_cur.taken = (is_bovf(cur.ir) && STATUS_IN[FLAG_OV])
                              || (is_bzero(cur.ir) && STATUS_IN[FLAG_Z]);
                if (is_toggle(cur.ir)) begin
                    next_cur.data  = DM_RDATA ^ bit_mask(cur.ir[11:9]);
                    next_cur.dm_wr = 1'b1;
                end
                if (is_clear(cur.ir)) begin
                    next_cur.data  = 8'h00;
                    next_cur.dm_wr = 1'b1;
                    next_cur.z_set = 1'b1;
                end
                if (is_call(cur.ir) && cur.ir[CALL_FAST_BIT]) begin
                    next_cur.w_sh    = W_IN;
                    next_cur.st_sh   = STATUS_IN;
                    next_cur.bank_sh = BANK_SELECT_IN;
                end
            end
            PH_Q4: begin
                next_cur.q = PH_Q1;
                if (cur.taken) begin
                    next_cur.pc    = branch_target;
                    next_cur.flush = 1'b1;
                    next_cur.taken = 1'b0;
                end
                if (is_call(cur.ir)) begin
                    // second word sits at the fetch address now
                    next_cur.pc    = {INSTR_DATA[11:0], cur.ir[7:0], 1'b0};
                    next_cur.flush = 1'b1;
                end
            end
            default: begin
                next_cur.q = PH_Q1;
            end
        endcase

        // read data captured in the setup phase, so the access needs no wait
        if (apb_setup) begin
            next_cur.pslverr = 1'b0;
            next_cur.prdata  = 32'h0000_0000;
            unique case (PADDR)
                REG_CTRL:   next_cur.prdata[CTRL_RUN] = cur.run;
                REG_PC:     next_cur.prdata[PC_W-1:0] = cur.pc;
                REG_SHADOW: begin
                    next_cur.prdata[SH_W_LSB +: 8]         = cur.w_sh;
                    next_cur.prdata[SH_STAT_LSB +: STAT_W] = cur.st_sh;
                    next_cur.prdata[SH_BANK_LSB +: BANK_W] = cur.bank_sh;
                end
                REG_RETTOP: next_cur.prdata[PC_W-1:0] = cur.return_stack_top;
                default:    next_cur.pslverr = 1'b1;
            endcase
        end
        if (apb_write && PADDR == REG_CTRL) begin
            next_cur.run = PWDATA[CTRL_RUN];
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            cur         <= '0;
            cur.q       <= PH_Q1;
            cur.ir      <= OP_NOP;
            cur.pc      <= PC_RESET;
            cur.run     <= CTRL_RESET_RUN;
        end else if (CE) begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign PROG_ADDR          = cur.pc;
    assign DM_ADDR            = cur.dm_addr;
    assign DM_RD              = cur.dm_rd;
    assign DM_WR              = cur.dm_wr;
    assign DM_WDATA           = cur.data;
    assign Z_SET              = cur.z_set;
    assign STACK_PUSH         = cur.push;
    assign RETURN_TOP         = cur.return_stack_top;
    assign WORKING_SHADOW     = cur.w_sh;
    assign FLAGS_SHADOW       = cur.st_sh;
    assign BANK_SELECT_SHADOW = cur.bank_sh;
    assign PRDATA             = cur.prdata;
    assign PSLVERR            = PSEL && PENABLE && cur.pslverr;
    assign PREADY             = PSEL && PENABLE;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_toggle_write:
    assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (CE && cur.q == PH_Q3 && is_toggle(cur.ir)) |=>
        (DM_WR && DM_WDATA == ($past(DM_RDATA) ^ bit_mask($past(cur.ir[11:9])))))
        else $error("toggle wrote wrong data");

    a_ovf_sample:
    assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (CE && cur.q == PH_Q3 && is_bovf(cur.ir)) |=> (cur.taken == $past(STATUS_IN[FLAG_OV])))
        else $error("overflow branch decision wrong");

    a_zero_sample:
    assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (CE && cur.q == PH_Q3 && is_bzero(cur.ir)) |=> (cur.taken == $past(STATUS_IN[FLAG_Z])))
        else $error("zero branch decision wrong");

    a_zero_taken:
    assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (CE && cur.q == PH_Q4 && cur.taken) |=> (cur.pc == $past(branch_target) && cur.flush))
        else $error("taken branch did not load target");

    a_not_taken_hold:
    assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (CE && cur.q == PH_Q4 && !cur.taken && !is_call(cur.ir)) |=> (cur.pc == $past(cur.pc) && !cur.flush))
        else $error("untaken branch changed pc");

    a_idle_cycle:
    assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (CE && cur.q == PH_Q1 && cur.run && cur.flush) |=> (cur.ir == OP_NOP && $stable(cur.pc)))
        else $error("idle cycle executed a word");

    a_call_push:
    assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (CE && cur.q == PH_Q2 && is_call(cur.ir)) |=> (STACK_PUSH && RETURN_TOP == PC_W'($past(cur.pc) + PC_STEP)))
        else $error("call pushed wrong return address");

    a_fast_save:
    assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (CE && cur.q == PH_Q3 && is_call(cur.ir) && cur.ir[CALL_FAST_BIT]) |=>
        (WORKING_SHADOW == $past(W_IN) && FLAGS_SHADOW == $past(STATUS_IN)
         && BANK_SELECT_SHADOW == $past(BANK_SELECT_IN)))
        else $error("fast call did not save");

    a_plain_keep:
    assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (CE && is_call(cur.ir) && !cur.ir[CALL_FAST_BIT]) |=>
        ($stable(WORKING_SHADOW) && $stable(FLAGS_SHADOW) && $stable(BANK_SELECT_SHADOW)))
        else $error("plain call changed shadows");

    a_call_target:
    assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (CE && cur.q == PH_Q4 && is_call(cur.ir)) |=>
        (cur.pc == {$past(INSTR_DATA[11:0]), $past(cur.ir[7:0]), 1'b0}))
        else $error("call target wrong");

    a_clear_zero:
    assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (CE && cur.q == PH_Q3 && is_clear(cur.ir)) |=> (DM_WR && DM_WDATA == 8'h00 && Z_SET))
        else $error("clear did not write zero");

    a_write_phase:
    assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        DM_WR |-> (cur.q == PH_Q4))
        else $error("data write outside Q4");

endmodule

// ==== verilog/branch_call_clear_pkg.sv ====
// shared constants for the branch, call and clear execute block
package branch_call_clear_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int PC_W     = 21;
    localparam int KLIT_W   = 20;
    localparam int DM_W     = 12;
    localparam int STAT_W   = 5;
    localparam int BANK_W   = 4;
    localparam int APB_AW   = 12;

    // ------------------------------------------------------------------
    // opcode fields
    // ------------------------------------------------------------------
    localparam logic [3:0]  OP_BIT_TOGGLE   = 4'h7;
    localparam logic [7:0]  OP_BRANCH_OVF   = 8'hE4;
    localparam logic [7:0]  OP_BRANCH_ZERO  = 8'hE0;
    localparam logic [6:0]  OP_CALL_FIRST   = 7'h76;
    localparam logic [3:0]  OP_CALL_SECOND  = 4'hF;
    localparam logic [6:0]  OP_CLEAR_REG    = 7'h35;
    localparam logic [15:0] OP_NOP          = 16'h0000;
    localparam int          CALL_FAST_BIT   = 8;
    localparam int          ACCESS_FLAG_BIT = 8;

    // ------------------------------------------------------------------
    // status flag positions and access bank split
    // ------------------------------------------------------------------
    localparam int          FLAG_Z          = 2;
    localparam int          FLAG_OV         = 3;
    localparam logic [7:0]  ACCESS_SPLIT    = 8'h80;
    localparam logic [3:0]  ACCESS_HI_BANK  = 4'hF;
    localparam logic [3:0]  ACCESS_LO_BANK  = 4'h0;

    // ------------------------------------------------------------------
    // program counter steps
    // ------------------------------------------------------------------
    localparam logic [PC_W-1:0] PC_STEP     = 21'h000002;
    localparam logic [PC_W-1:0] PC_RESET    = 21'h000000;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [APB_AW-1:0] REG_CTRL    = 12'h000;
    localparam logic [APB_AW-1:0] REG_PC      = 12'h004;
    localparam logic [APB_AW-1:0] REG_SHADOW  = 12'h008;
    localparam logic [APB_AW-1:0] REG_RETTOP  = 12'h00C;
    localparam int                CTRL_RUN    = 0;
    localparam logic              CTRL_RESET_RUN = 1'b1;
    localparam int                SH_W_LSB    = 0;
    localparam int                SH_STAT_LSB = 8;
    localparam int                SH_BANK_LSB = 16;

    // ------------------------------------------------------------------
    // instruction cycle phases
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        PH_Q1 = 4'b0001,
        PH_Q2 = 4'b0010,
        PH_Q3 = 4'b0100,
        PH_Q4 = 4'b1000
    } phase_type;

endpackage

// ==== verilog/branch_target_calc.sv ====
// relative branch target adder
`timescale 1ns/100ps
module branch_target_calc (
    // operands
    input  wire logic [branch_call_clear_pkg::PC_W-1:0] pc_now,
    input  wire logic [7:0]                             offset,
    // result
    output logic      [branch_call_clear_pkg::PC_W-1:0] target
);
    import branch_call_clear_pkg::*;

    logic [PC_W-1:0] step;

    // offset is signed words; doubled to bytes
    always_comb begin
        step   = {{(PC_W-9){offset[7]}}, offset, 1'b0};
        target = PC_W'(pc_now + step);
    end

endmodule
